// >>> psp_params.svh
`ifndef PSP_PARAMS_SVH
`define PSP_PARAMS_SVH
`define PSP_ADDR_W          8
`define PSP_OFF_DATA        8'h08
`define PSP_OFF_CTLPIN      8'h09
`define PSP_OFF_FLAG        8'h0C
`define PSP_OFF_CSR         8'h89
`define PSP_OFF_ENABLE      8'h8C
`define PSP_OFF_DATA_DIR    8'h88
`define PSP_CSR_IBF         7
`define PSP_CSR_OBF         6
`define PSP_CSR_INPUT_OVERFLOW_FLAG        5
`define PSP_CSR_MODE        4
`define PSP_FLAG_IRQ        7
`define PSP_CSR_RESET       8'h07
`define PSP_FLAG_RESET      8'h00
`define PSP_ENABLE_RESET    8'h00
`define PSP_DATA_DIR_RESET  8'hFF
`define PSP_CTLPIN_MASK     8'h07
`define PSP_PHASES          2'h3
`endif

// >>> psp_pkg.sv
package psp_pkg;
	typedef struct packed {
		logic rd_n;
		logic wr_n;
		logic cs_n;
	} psp_strobe_t;
	typedef struct packed {
		logic [7:0] data_o;
		logic [7:0] data_oe;
		logic [2:0] ctl_o;
		logic [2:0] ctl_oe;
	} psp_pin_out_t;
	typedef enum logic [2:0] {
		PSP_IDLE = 3'b001,
		PSP_BUSY = 3'b010,
		PSP_DONE = 3'b100
	} psp_state_t;
endpackage : psp_pkg

// >>> psp_port.sv
// Operation
// - Mode bit turns the data port into an externally accessed slave port.
// - Control pins become read, write and select strobe inputs in mode.
// - Firmware writes outgoing latch; firmware reads incoming latch, same address.
// - In mode, data direction register ignored; strobes steer bus drive.
// - External write starts with select and write strobe both low.
// - Input-full sets on phase four after next phase two after release.
// - Interrupt flag sets on that same phase four after a write.
// - Input-full clears on firmware read of incoming latch, or when mode goes off.
// - Write completing while input still full sets overflow.
// - External read clears output-full at once and drives outgoing latch.
// - Interrupt flag sets on phase four after next phase two, read end.
// - Output-full stays clear until firmware writes the data port.
// - Outside mode full flags held clear; overflow kept until firmware clears.
// - Interrupt flag sticky until firmware clears; enable masks request.
// - General I/O reads return pin levels, writes update output latch.
// - Bit-modify reads pins, changes bit, writes result into latch.
// - Writes land on the next clock in any phase; data-port bit-modify uses pins sampled at cycle start.
// - Reset loads control/status with zeros above, ones in direction bits.
// - Unimplemented bits of control port and control/status read zero.
`include "psp_params.svh"
`timescale 1ns/1ps
`default_nettype none
module psp_port
	import psp_pkg::*;
(
	input  wire logic                   ref_clk,
	input  wire logic                   rst_b,
	input  wire logic [`PSP_ADDR_W-1:0] reg_addr,
	input  wire logic [7:0]             reg_wdata,
	input  wire logic                   reg_wr,
	input  wire logic                   reg_rd,
	input  wire logic                   bit_modify,
	input  wire logic [2:0]             bit_index,
	input  wire logic                   bit_value,
	output logic      [7:0]             reg_rdata,
	input  wire logic [7:0]             data_i,
	input  wire logic [2:0]             ctl_i,
	output psp_pin_out_t                pins,
	output logic                        irq
);

	////////////////////////////////////////////////////////////////////////
	// Registers and phase counter
	logic [7:0]  out_latch;
	logic [7:0]  in_latch;
	logic [7:0]  data_dir;
	logic [2:0]  ctl_latch;
	logic [2:0]  ctl_dir;
	logic        mode;
	logic        in_full;
	logic        out_full;
	logic        overflow;
	logic        irq_flag;
	logic [6:0]  flag_rest;
	logic [7:0]  enable_reg;
	logic [1:0]  phase;
	logic        phase_two;
	logic        phase_four;
	logic [2:0]  ctl_s1;
	logic [2:0]  ctl_s2;
	logic [7:0]  pin_sample;
	psp_strobe_t stb;
	psp_state_t  wr_st;
	psp_state_t  rd_st;
	logic        wr_active;
	logic        rd_active;
	logic        wr_done;
	logic        rd_done;
	logic        rd_start;
	logic        fw_data_wr;
	logic        fw_data_rd;
	logic [7:0]  modify_val;
	logic        mode_off;

	localparam logic [7:0] CSR_RST = `PSP_CSR_RESET;

	// Four clocks form one instruction cycle
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b)
			phase <= 2'h0;
		else
			phase <= phase + 2'h1;
	end
	assign phase_two  = (phase == 2'h1);
	assign phase_four = (phase == `PSP_PHASES);

	////////////////////////////////////////////////////////////////////////
	// Strobe synchroniser
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			ctl_s1 <= 3'h7;
			ctl_s2 <= 3'h7;
		end else begin
			ctl_s1 <= ctl_i;
			ctl_s2 <= ctl_s1;
		end
	end
	// Pin order: bit0 read, bit1 write, bit2 select
	assign stb.rd_n = ctl_s2[0];
	assign stb.wr_n = ctl_s2[1];
	assign stb.cs_n = ctl_s2[2];
	assign wr_active = mode && !stb.cs_n && !stb.wr_n;
	assign rd_active = mode && !stb.cs_n && !stb.rd_n;

	////////////////////////////////////////////////////////////////////////
	// External write and read sequencers
	// Release waits for phase two, then completes on the following phase four
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b)
			wr_st <= PSP_IDLE;
		else if (!mode)
			wr_st <= PSP_IDLE;
		else begin
			unique case (wr_st)
				PSP_IDLE: if (wr_active) wr_st <= PSP_BUSY;
				PSP_BUSY: if (!wr_active && phase_two) wr_st <= PSP_DONE;
				PSP_DONE: if (phase_four) wr_st <= PSP_IDLE;
				default:  wr_st <= PSP_IDLE;
			endcase
		end
	end
	assign wr_done = (wr_st == PSP_DONE) && phase_four;

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b)
			rd_st <= PSP_IDLE;
		else if (!mode)
			rd_st <= PSP_IDLE;
		else begin
			unique case (rd_st)
				PSP_IDLE: if (rd_active) rd_st <= PSP_BUSY;
				PSP_BUSY: if (!rd_active && phase_two) rd_st <= PSP_DONE;
				PSP_DONE: if (phase_four) rd_st <= PSP_IDLE;
				default:  rd_st <= PSP_IDLE;
			endcase
		end
	end
	assign rd_done  = (rd_st == PSP_DONE) && phase_four;
	assign rd_start = (rd_st == PSP_IDLE) && rd_active;

	////////////////////////////////////////////////////////////////////////
	// Firmware access decode
	assign fw_data_wr = reg_wr && (reg_addr == `PSP_OFF_DATA);
	assign fw_data_rd = reg_rd && (reg_addr == `PSP_OFF_DATA) && mode;
	// Mode switching off clears the full flags in the same edge
	assign mode_off   = !mode || (reg_wr && reg_addr == `PSP_OFF_CSR &&
	                              !reg_wdata[`PSP_CSR_MODE]);

	// Pins sampled at cycle start; late writes are seen a cycle later
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b)
			pin_sample <= 8'h00;
		else if (phase == 2'h0)
			pin_sample <= data_i;
	end

	// Bit-modify uses pin levels, not the latch
	always_comb begin
		if (reg_addr == `PSP_OFF_CTLPIN)
			modify_val = {5'h00, ctl_i};
		else
			modify_val = pin_sample;
		modify_val[bit_index] = bit_value;
	end

	////////////////////////////////////////////////////////////////////////
	// Data latches
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b)
			out_latch <= 8'h00;
		else if (reg_wr && reg_addr == `PSP_OFF_DATA)
			out_latch <= bit_modify ? modify_val : reg_wdata;
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b)
			in_latch <= 8'h00;
		// Raw strobes: the synchronised ones lag past the master's data hold
		else if (mode && !ctl_i[2] && !ctl_i[1])
			in_latch <= data_i;
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			ctl_latch <= 3'h0;
			data_dir  <= `PSP_DATA_DIR_RESET;
		end else if (reg_wr) begin
			if (reg_addr == `PSP_OFF_CTLPIN)
				ctl_latch <= bit_modify ? modify_val[2:0] : reg_wdata[2:0];
			if (reg_addr == `PSP_OFF_DATA_DIR)
				data_dir <= reg_wdata;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Control/status register
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			mode    <= CSR_RST[`PSP_CSR_MODE];
			ctl_dir <= CSR_RST[2:0];
		end else if (reg_wr && reg_addr == `PSP_OFF_CSR) begin
			mode    <= reg_wdata[`PSP_CSR_MODE];
			ctl_dir <= reg_wdata[2:0];
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b)
			in_full <= 1'b0;
		else if (mode_off)
			in_full <= 1'b0;
		else if (wr_done)
			in_full <= 1'b1;
		else if (fw_data_rd)
			in_full <= 1'b0;
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b)
			out_full <= 1'b0;
		else if (mode_off)
			out_full <= 1'b0;
		else if (rd_start)
			out_full <= 1'b0;
		else if (fw_data_wr)
			out_full <= 1'b1;
	end

	// Only firmware clears overflow, and a new one beats the clear
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b)
			overflow <= 1'b0;
		else if (wr_done && in_full && !fw_data_rd)
			overflow <= 1'b1;
		else if (reg_wr && reg_addr == `PSP_OFF_CSR)
			overflow <= reg_wdata[`PSP_CSR_INPUT_OVERFLOW_FLAG] & overflow;
	end

	////////////////////////////////////////////////////////////////////////
	// Interrupt flag and enable
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			irq_flag  <= 1'b0;
			flag_rest <= 7'h00;
		end else begin
			if (wr_done || rd_done)
				irq_flag <= 1'b1;
			else if (reg_wr && reg_addr == `PSP_OFF_FLAG)
				irq_flag <= reg_wdata[`PSP_FLAG_IRQ];
			if (reg_wr && reg_addr == `PSP_OFF_FLAG)
				flag_rest <= reg_wdata[6:0];
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b)
			enable_reg <= `PSP_ENABLE_RESET;
		else if (reg_wr && reg_addr == `PSP_OFF_ENABLE)
			enable_reg <= reg_wdata;
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b)
			irq <= 1'b0;
		else
			irq <= irq_flag && enable_reg[`PSP_FLAG_IRQ];
	end

	////////////////////////////////////////////////////////////////////////
	// Read data, one cycle after strobe
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b)
			reg_rdata <= 8'h00;
		else if (reg_rd) begin
			unique case (reg_addr)
				`PSP_OFF_DATA:     reg_rdata <= mode ? in_latch : data_i;
				`PSP_OFF_CTLPIN:   reg_rdata <= {5'h00, ctl_i};
				`PSP_OFF_FLAG:     reg_rdata <= {irq_flag, flag_rest};
				`PSP_OFF_CSR:      reg_rdata <= {in_full, out_full, overflow,
				                                 mode, 1'b0, ctl_dir};
				`PSP_OFF_ENABLE:   reg_rdata <= enable_reg;
				`PSP_OFF_DATA_DIR: reg_rdata <= data_dir;
				default:           reg_rdata <= 8'h00;
			endcase
		end else
			reg_rdata <= 8'h00;
	end

	////////////////////////////////////////////////////////////////////////
	// Pin drive
	// Bus drive is combinational on the raw pins for a fast external read
	always_comb begin
		pins.data_o  = out_latch;
		pins.data_oe = mode ? {8{!ctl_i[2] && !ctl_i[0]}} : ~data_dir;
		pins.ctl_o   = ctl_latch;
		pins.ctl_oe  = mode ? 3'h0 : ~ctl_dir;
	end

endmodule : psp_port
`default_nettype wire

// >>> psp_port_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module psp_port_monitor
	import psp_pkg::*;
(
	input wire logic         ref_clk,
	input wire logic         rst_b,
	input wire logic [7:0]   reg_addr,
	input wire logic [7:0]   reg_wdata,
	input wire logic         reg_wr,
	input wire logic         reg_rd,
	input wire logic         bit_modify,
	input wire logic [7:0]   reg_rdata,
	input wire logic [2:0]   ctl_i,
	input wire psp_pin_out_t pins,
	input wire logic         irq
);
	logic       mode_q;
	logic       en_q;
	logic [7:0] out_q;
	logic       fl_wr;
	assign fl_wr = reg_wr && (reg_addr == 8'h0C || reg_addr == 8'h8C);
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			mode_q <= 1'b0;
			en_q <= 1'b0;
			out_q <= 8'h00;
		end else if (reg_wr && !bit_modify) begin
			mode_q <= (reg_addr == 8'h89) ? reg_wdata[4] : mode_q;
			en_q <= (reg_addr == 8'h8C) ? reg_wdata[7] : en_q;
			out_q <= (reg_addr == 8'h08) ? reg_wdata : out_q;
		end
	end
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	AST_CSR_GAP: assert property ($past(reg_rd) && $past(reg_addr) == 8'h89
		|-> reg_rdata[3] == 1'b0) else $error("csr bit3 not zero");
	AST_CTL_UPPER: assert property ($past(reg_rd) && $past(reg_addr) == 8'h09
		|-> reg_rdata[7:3] == 5'h00) else $error("ctl port upper bits set");
	AST_READ_DRIVE: assert property (mode_q && !ctl_i[2] && !ctl_i[0]
		|-> pins.data_oe == 8'hFF) else $error("bus not driven in read");
	AST_NO_DRIVE: assert property (mode_q && (ctl_i[2] || ctl_i[0])
		|-> pins.data_oe == 8'h00) else $error("bus driven outside read");
	AST_DRIVE_LATCH: assert property (mode_q && pins.data_oe == 8'hFF
		|-> pins.data_o == out_q) else $error("wrong byte driven");
	AST_IRQ_MASK: assert property (!en_q && !$past(en_q) |-> !irq)
		else $error("irq while masked");
	AST_IRQ_STICKY: assert property (irq && !fl_wr && !$past(fl_wr)
		|=> irq) else $error("irq dropped by itself");
	AST_WR_LATE: assert property (mode_q && $rose(ctl_i[1]) && !irq
		|-> ##1 !irq) else $error("write end flagged too early");
	AST_WR_DONE: assert property (en_q && mode_q && $rose(ctl_i[1])
		&& !$past(ctl_i[2]) |-> ##[3:12] irq) else $error("write not flagged");
	AST_RD_DONE: assert property (en_q && mode_q && $rose(ctl_i[0])
		&& !$past(ctl_i[2]) |-> ##[3:12] irq) else $error("read not flagged");
	cover property (mode_q && !ctl_i[2] && !ctl_i[1]);
	cover property (mode_q && !ctl_i[2] && !ctl_i[0]);
	cover property ($rose(irq));
endmodule : psp_port_monitor
`default_nettype wire

// >>> psp_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module psp_host_model
	import psp_pkg::*;
(
	input  wire logic       ref_clk,
	input  wire logic [7:0] dev_o,
	input  wire logic [7:0] dev_oe,
	output logic      [2:0] ctl,
	output logic      [7:0] lvl
);
	logic [7:0] drv = 8'h00;
	initial ctl = 3'h7;
	// Device wins on the bits it drives
	assign lvl = (dev_oe & dev_o) | (~dev_oe & drv);
	task xfer(input logic w, input logic [7:0] d, input int len,
		output logic [7:0] q);
		ctl <= w ? 3'h1 : 3'h2;
		drv <= w ? d : drv;
		repeat (len) @(posedge ref_clk);
		q = lvl;
		ctl <= 3'h7;
		// After a write the released bus shows the inverse; a read leaves the drive byte as it was
		drv <= w ? ~d : drv;
		repeat (12) @(posedge ref_clk);
	endtask : xfer
endmodule : psp_host_model
`default_nettype wire

// >>> tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin error_cnt++; \
	$display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module tb;
	import psp_pkg::*;
	logic         ref_clk = 0, rst_b = 0, reg_wr = 0, reg_rd = 0, rd_d = 0;
	logic         bit_modify = 0, bit_value = 0, irq;
	logic [7:0]   reg_addr = 0, reg_wdata = 0, reg_rdata, data_i, a, b, q, exp_v;
	logic [2:0]   bit_index = 0, ctl_i;
	psp_pin_out_t pins;
	logic [7:0]   exp_q[$];
	int           error_cnt = 0, total_checks = 0;
	always #20 ref_clk = ~ref_clk;
	psp_port i_psp_port(.ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.bit_modify(bit_modify), .bit_index(bit_index), .bit_value(bit_value),
		.reg_rdata(reg_rdata), .data_i(data_i), .ctl_i(ctl_i), .pins(pins),
		.irq(irq));
	psp_host_model i_psp_host_model(.ref_clk(ref_clk), .dev_o(pins.data_o),
		.dev_oe(pins.data_oe), .ctl(ctl_i), .lvl(data_i));
	task final_report;
		if (error_cnt == 0 && total_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : final_report
	task op(input logic w, r, m, input logic [7:0] ad, d, e);
		reg_wr <= w;
		reg_rd <= r;
		bit_modify <= m;
		reg_addr <= ad;
		reg_wdata <= d;
		bit_index <= d[2:0];
		bit_value <= d[3];
		if (r) exp_q.push_back(e);
		@(posedge ref_clk);
	endtask : op
	task idle;
		op(0, 0, 0, 8'h00, 8'h00, 8'h00);
	endtask : idle
	// Read data stands only in the cycle after the strobe
	always @(posedge ref_clk) begin
		if (rd_d) begin
			exp_v = exp_q.pop_front();
			`CHK(reg_rdata, exp_v)
		end
		rd_d <= reg_rd;
	end
	initial begin
		repeat (3000) @(posedge ref_clk);
		error_cnt++;
		final_report();
	end
	initial begin
		void'($urandom(50594));
		a = 8'($urandom);
		b = 8'($urandom);
		repeat (2) @(posedge ref_clk);
		rst_b <= 1;
		@(posedge ref_clk);
		op(0, 1, 0, 8'h89, 0, 8'h07);
		op(0, 1, 0, 8'h0C, 0, 8'h00);
		op(0, 1, 0, 8'h55, 0, 8'h00);
		op(0, 1, 0, 8'h09, 0, 8'h07);
		`CHK(pins.ctl_oe, 3'h0)
		op(1, 0, 0, 8'h09, 8'hFD, 0);
		idle();
		`CHK(pins.ctl_o, 3'h5)
		op(1, 0, 0, 8'h88, 8'h00, 0);
		op(1, 0, 0, 8'h08, a, 0);
		idle();
		op(0, 1, 0, 8'h08, 0, a);
		// Modify sees pins only after the next instruction-cycle start
		repeat (2) idle();
		op(1, 0, 1, 8'h08, 8'h0D, 0);
		idle();
		op(0, 1, 0, 8'h08, 0, a | 8'h20);
		op(1, 0, 0, 8'h88, 8'hFF, 0);
		i_psp_host_model.drv <= b;
		idle();
		op(0, 1, 0, 8'h08, 0, b);
		repeat (2) idle();
		op(1, 0, 1, 8'h08, 8'h00, 0);
		op(1, 0, 0, 8'h88, 8'h00, 0);
		idle();
		op(0, 1, 0, 8'h08, 0, b & 8'hFE);
		op(1, 0, 0, 8'h8C, 8'h80, 0);
		op(1, 0, 0, 8'h89, 8'h17, 0);
		op(1, 0, 0, 8'h08, a, 0);
		op(0, 1, 0, 8'h89, 0, 8'h57);
		idle();
		i_psp_host_model.xfer(1, b, 3, q);
		op(0, 1, 0, 8'h89, 0, 8'hD7);
		op(0, 1, 0, 8'h0C, 0, 8'h80);
		`CHK(irq, 1'b1)
		idle();
		i_psp_host_model.xfer(0, 0, 6, q);
		`CHK(q, a)
		op(0, 1, 0, 8'h89, 0, 8'h97);
		op(0, 1, 0, 8'h08, 0, b);
		op(0, 1, 0, 8'h89, 0, 8'h17);
		idle();
		i_psp_host_model.xfer(1, a, 3, q);
		i_psp_host_model.xfer(1, ~a, 3, q);
		op(0, 1, 0, 8'h89, 0, 8'hB7);
		op(0, 1, 0, 8'h08, 0, ~a);
		op(1, 0, 0, 8'h0C, 8'h00, 0);
		idle();
		idle();
		`CHK(irq, 1'b0)
		op(1, 0, 0, 8'h8C, 8'h00, 0);
		idle();
		i_psp_host_model.xfer(1, b, 3, q);
		`CHK(irq, 1'b0)
		op(0, 1, 0, 8'h0C, 0, 8'h80);
		op(1, 0, 0, 8'h89, 8'h27, 0);
		op(0, 1, 0, 8'h89, 0, 8'h27);
		op(1, 0, 0, 8'h89, 8'h07, 0);
		op(0, 1, 0, 8'h89, 0, 8'h07);
		op(1, 0, 0, 8'h8C, 8'h80, 0);
		op(1, 0, 0, 8'h89, 8'h13, 0);
		idle();
		// Second reset in mid-run must restore the power-up values
		rst_b <= 0;
		repeat (2) @(posedge ref_clk);
		rst_b <= 1;
		@(posedge ref_clk);
		op(0, 1, 0, 8'h89, 0, 8'h07);
		op(0, 1, 0, 8'h8C, 0, 8'h00);
		idle();
		idle();
		final_report();
	end
endmodule : tb
bind psp_port psp_port_monitor i_psp_port_monitor(.ref_clk(ref_clk),
	.rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .bit_modify(bit_modify),
	.reg_rdata(reg_rdata), .ctl_i(ctl_i), .pins(pins), .irq(irq));
`default_nettype wire
